// ### twb_pkg.sv
// shared constants for the two-wire bus port and its master
package twb_pkg;
    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned CMD_WAIT_US         = 100;
    localparam int unsigned CMD_WAIT_CYCLES     = (CMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POR_CYCLES_DEF      = 16;
    localparam int unsigned SCL_HALF_DEF        = 8;
    localparam int unsigned BITS_PER_BYTE       = 8;
    localparam logic [3:0]  BIT_CNT_ACK         = 4'h8;
    localparam logic [3:0]  BIT_CNT_FIRST       = 4'h0;
    localparam logic [7:0]  BYTE_ZERO           = 8'h00;
endpackage : twb_pkg

// ### twb_if.sv
// two-wire bus carrier with wired-and resolution of both lines
`timescale 1ns/10ps
interface twb_if;
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;
    // pull-up gives the high level; any enabled low driver wins
    assign scl = !(scl_oe_m && !scl_o_m);
    assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
    modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
                    input scl, input sda);
    modport slave  (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface : twb_if

// ### twb_sync.sv
// two-flop synchroniser with edge detection on the settled level
`timescale 1ns/10ps
module twb_sync
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    typedef struct packed
    {
        logic meta;
        logic sync;
        logic last;
    } sync_s;
    sync_s st_ff;
    sync_s nxt_st;
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.meta = pin_i;
        nxt_st.sync = st_ff.meta;
        nxt_st.last = st_ff.sync;
    end
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= '1;
        else
            st_ff <= nxt_st;
    end
    assign level_o = st_ff.sync;
    assign rise_o  = st_ff.sync && !st_ff.last;
    assign fall_o  = !st_ff.sync && st_ff.last;
endmodule : twb_sync

// ### twb_slave.sv
// device end: bit-level two-wire slave port with power-on hold-off
`timescale 1ns/10ps
module twb_slave
#(
    parameter int unsigned POR_CYCLES = twb_pkg::POR_CYCLES_DEF
)
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    twb_if.slave      bus,
    input  wire logic tx_mode_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic ack_en_i,
    input  wire logic write_busy_i,
    output logic      ready_o,
    output logic      active_o,
    output logic      start_o,
    output logic      stop_o,
    output logic      rx_valid_o,
    output logic [7:0] rx_byte_o,
    output logic      tx_taken_o,
    output logic      master_ack_o
);
    import twb_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        ST_RESET   = 2'b00,
        ST_STANDBY = 2'b01,
        ST_ACTIVE  = 2'b10,
        ST_WAITWR  = 2'b11
    } mode_e;
    typedef struct packed
    {
        mode_e       mode;
        logic [15:0] por_cnt;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic        tx;
        logic        sda_low;
        logic        start;
        logic        stop;
        logic        rx_valid;
        logic [7:0]  rx_byte;
        logic        tx_taken;
        logic        mack;
        logic        hi_seen;
        logic        ready;
        logic        active;
    } slv_s;
    slv_s st_ff;
    slv_s nxt_st;
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    twb_sync u_scl (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pin_i(bus.scl),
                    .level_o(scl_lvl), .rise_o(scl_rise), .fall_o(scl_fall));
    twb_sync u_sda (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pin_i(bus.sda),
                    .level_o(sda_lvl), .rise_o(sda_rise), .fall_o(sda_fall));
    // ----------------------------------------
    // protocol engine
    // ----------------------------------------
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.start    = 1'b0;
        nxt_st.stop     = 1'b0;
        nxt_st.rx_valid = 1'b0;
        nxt_st.tx_taken = 1'b0;
        case (st_ff.mode)
            ST_RESET:
            begin
                // bus events ignored while the power-on count runs
                nxt_st.sda_low = 1'b0;
                if (st_ff.por_cnt >= 16'(POR_CYCLES - 1))
                    nxt_st.mode = ST_STANDBY;
                else
                    nxt_st.por_cnt = st_ff.por_cnt + 16'h0001;
            end
            ST_STANDBY, ST_ACTIVE, ST_WAITWR:
            begin
                // the write cycle has ended: standby follows
                if (st_ff.mode == ST_WAITWR && !write_busy_i)
                    nxt_st.mode = ST_STANDBY;
                if (scl_lvl && sda_fall)
                begin
                    // start, or repeated start: re-arm at bit zero
                    nxt_st.mode    = ST_ACTIVE;
                    nxt_st.start   = 1'b1;
                    nxt_st.hi_seen = 1'b0;
                    nxt_st.bit_cnt = BIT_CNT_FIRST;
                    nxt_st.tx      = 1'b0;
                    nxt_st.sda_low = 1'b0;
                end
                else if (scl_lvl && sda_rise)
                begin
                    nxt_st.stop    = (st_ff.mode == ST_ACTIVE);
                    nxt_st.mode    = write_busy_i ? ST_WAITWR : ST_STANDBY;
                    nxt_st.sda_low = 1'b0;
                end
                else if (st_ff.mode == ST_ACTIVE)
                begin
                    if (scl_rise)
                    begin
                        nxt_st.hi_seen = 1'b1;
                        if (st_ff.bit_cnt == BIT_CNT_ACK)
                        begin
                            nxt_st.mack = !sda_lvl;
                            if (st_ff.tx && !sda_lvl)
                                nxt_st.tx_taken = 1'b1;
                        end
                        else
                        begin
                            // a transmitter shifts on the fall only, else bits are skipped
                            if (!st_ff.tx)
                                nxt_st.shreg = {st_ff.shreg[6:0], sda_lvl};
                            if (st_ff.bit_cnt == BIT_CNT_ACK - 4'h1 && !st_ff.tx)
                            begin
                                nxt_st.rx_valid = 1'b1;
                                nxt_st.rx_byte  = {st_ff.shreg[6:0], sda_lvl};
                            end
                        end
                    end
                    else if (scl_fall && st_ff.hi_seen)
                    begin
                        // the fall that closes a start condition ends no bit
                        nxt_st.hi_seen = 1'b0;
                        if (st_ff.bit_cnt == BIT_CNT_ACK)
                        begin
                            // ninth clock over: release, or drive bit 7 if transmitting; start next byte
                            nxt_st.bit_cnt = BIT_CNT_FIRST;
                            nxt_st.tx      = st_ff.tx ? st_ff.mack : tx_mode_i;
                            nxt_st.shreg   = tx_byte_i;
                            nxt_st.sda_low = (st_ff.tx ? st_ff.mack : tx_mode_i) && !tx_byte_i[7];
                            if (st_ff.tx && !st_ff.mack)
                                nxt_st.tx = 1'b0;
                        end
                        else
                        begin
                            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                            if (st_ff.bit_cnt == BIT_CNT_ACK - 4'h1)
                                nxt_st.sda_low = !st_ff.tx && ack_en_i;
                            else if (st_ff.tx)
                                nxt_st.sda_low = !st_ff.shreg[BITS_PER_BYTE - 2];
                            else
                                nxt_st.sda_low = 1'b0;
                            if (st_ff.tx)
                                nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                        end
                    end
                end
            end
            default:
                nxt_st.mode = ST_RESET;
        endcase
        // status flags leave from flops like every other output
        nxt_st.ready  = (nxt_st.mode != ST_RESET);
        nxt_st.active = (nxt_st.mode == ST_ACTIVE);
    end
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff         <= '0;
            st_ff.mode    <= ST_RESET;
            st_ff.bit_cnt <= BIT_CNT_FIRST;
            st_ff.shreg   <= BYTE_ZERO;
            st_ff.rx_byte <= BYTE_ZERO;
        end
        else
            st_ff <= nxt_st;
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus.sda_o_s   = 1'b0;
    assign bus.sda_oe_s  = st_ff.sda_low;
    assign ready_o       = st_ff.ready;
    assign active_o      = st_ff.active;
    assign start_o       = st_ff.start;
    assign stop_o        = st_ff.stop;
    assign rx_valid_o    = st_ff.rx_valid;
    assign rx_byte_o     = st_ff.rx_byte;
    assign tx_taken_o    = st_ff.tx_taken;
    assign master_ack_o  = st_ff.mack;
endmodule : twb_slave

// ### twb_master.sv
// host end: two-wire bus master that frames one byte per request
`timescale 1ns/10ps
module twb_master
#(
    parameter int unsigned WAIT_CYCLES = twb_pkg::CMD_WAIT_CYCLES,
    parameter int unsigned SCL_HALF    = twb_pkg::SCL_HALF_DEF
)
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    twb_if.master     bus,
    input  wire logic req_i,
    input  wire logic with_start_i,
    input  wire logic with_stop_i,
    input  wire logic read_i,
    input  wire logic ack_i,
    input  wire logic [7:0] wdata_i,
    output logic      busy_o,
    output logic      done_o,
    output logic [7:0] rdata_o,
    output logic      acked_o
);
    import twb_pkg::*;
    typedef enum logic [2:0]
    {
        M_POWER = 3'b000,
        M_IDLE  = 3'b001,
        M_START = 3'b010,
        M_LOW   = 3'b011,
        M_HIGH  = 3'b100,
        M_STOPL = 3'b101,
        M_STOPH = 3'b110,
        M_RSTRT = 3'b111
    } mst_e;
    typedef struct packed
    {
        mst_e        st;
        logic [19:0] cnt;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic        rd;
        logic        ack;
        logic        stop;
        logic        scl_low;
        logic        sda_low;
        logic        done;
        logic [7:0]  rdata;
        logic        acked;
        logic        sda_meta;
        logic        sda_sync;
        logic        busy;
    } mst_s;
    mst_s m_ff;
    mst_s nxt_m;
    wire half_done = (m_ff.cnt >= 20'(SCL_HALF - 1));
    always_comb
    begin
        nxt_m          = m_ff;
        nxt_m.done     = 1'b0;
        nxt_m.cnt      = m_ff.cnt + 20'h00001;
        nxt_m.sda_meta = bus.sda;
        nxt_m.sda_sync = m_ff.sda_meta;
        case (m_ff.st)
            M_POWER:
                if (m_ff.cnt >= 20'(WAIT_CYCLES - 1))
                begin
                    nxt_m.st  = M_IDLE;
                    nxt_m.cnt = '0;
                end
            M_IDLE:
            begin
                nxt_m.cnt = '0;
                if (req_i)
                begin
                    nxt_m.shreg   = wdata_i;
                    nxt_m.rd      = read_i;
                    nxt_m.ack     = ack_i;
                    nxt_m.stop    = with_stop_i;
                    nxt_m.bit_cnt = BIT_CNT_FIRST;
                    if (with_start_i && m_ff.scl_low)
                    begin
                        // repeated start: sda is freed first while scl stays low
                        nxt_m.st      = M_RSTRT;
                        nxt_m.sda_low = 1'b0;
                    end
                    else if (with_start_i)
                    begin
                        nxt_m.st      = M_START;
                        nxt_m.sda_low = 1'b1;
                    end
                    else
                    begin
                        // frame goes on: first bit is set up while scl is low
                        nxt_m.st      = M_LOW;
                        nxt_m.sda_low = !read_i && !wdata_i[BITS_PER_BYTE - 1];
                    end
                end
            end
            M_START:
                if (half_done)
                begin
                    nxt_m.scl_low = 1'b1;
                    nxt_m.sda_low = !m_ff.rd && !m_ff.shreg[7];
                    nxt_m.st      = M_LOW;
                    nxt_m.cnt     = '0;
                end
            M_LOW:
                if (half_done)
                begin
                    nxt_m.scl_low = 1'b0;
                    nxt_m.st      = M_HIGH;
                    nxt_m.cnt     = '0;
                end
            M_HIGH:
                if (half_done)
                begin
                    nxt_m.scl_low = 1'b1;
                    nxt_m.cnt     = '0;
                    if (m_ff.bit_cnt == BIT_CNT_ACK)
                    begin
                        nxt_m.acked   = !m_ff.sda_sync;
                        nxt_m.done    = 1'b1;
                        nxt_m.sda_low = m_ff.stop;
                        nxt_m.st      = m_ff.stop ? M_STOPL : M_IDLE;
                    end
                    else
                    begin
                        nxt_m.shreg   = {m_ff.shreg[6:0], m_ff.sda_sync};
                        nxt_m.bit_cnt = m_ff.bit_cnt + 4'h1;
                        nxt_m.st      = M_LOW;
                        if (m_ff.bit_cnt == BIT_CNT_ACK - 4'h1)
                        begin
                            nxt_m.rdata   = {m_ff.shreg[6:0], m_ff.sda_sync};
                            nxt_m.sda_low = m_ff.rd && m_ff.ack;
                        end
                        else
                            nxt_m.sda_low = !m_ff.rd && !m_ff.shreg[6];
                    end
                end
            M_STOPL:
                if (half_done)
                begin
                    nxt_m.scl_low = 1'b0;
                    nxt_m.st      = M_STOPH;
                    nxt_m.cnt     = '0;
                end
            M_STOPH:
                if (half_done)
                begin
                    nxt_m.sda_low = 1'b0;
                    nxt_m.st      = M_IDLE;
                    nxt_m.cnt     = '0;
                end
            M_RSTRT:
            begin
                // low half with sda free, then scl high for a half before sda drops
                if (m_ff.cnt == 20'(SCL_HALF - 1))
                    nxt_m.scl_low = 1'b0;
                if (m_ff.cnt >= 20'(2 * SCL_HALF - 1))
                begin
                    nxt_m.sda_low = 1'b1;
                    nxt_m.st      = M_START;
                    nxt_m.cnt     = '0;
                end
            end
            default:
                nxt_m.st = M_IDLE;
        endcase
        nxt_m.busy = (nxt_m.st != M_IDLE);
    end
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            m_ff          <= '0;
            m_ff.st       <= M_POWER;
            m_ff.sda_meta <= 1'b1;
            m_ff.sda_sync <= 1'b1;
            m_ff.busy     <= 1'b1;
        end
        else
            m_ff <= nxt_m;
    end
    // scl is held low between bytes of a frame, so no stray edges occur
    assign bus.scl_o_m  = 1'b0;
    assign bus.scl_oe_m = m_ff.scl_low;
    assign bus.sda_o_m  = 1'b0;
    assign bus.sda_oe_m = m_ff.sda_low;
    assign busy_o       = m_ff.busy;
    assign done_o       = m_ff.done;
    assign rdata_o      = m_ff.rdata;
    assign acked_o      = m_ff.acked;
endmodule : twb_master

// ### twb_bus_properties.sv
// concurrent checks on the two-wire bus lines between both ends
`timescale 1ns/10ps
module twb_bus_properties
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic scl_o_m,
    input  wire logic scl_oe_m,
    input  wire logic sda_o_m,
    input  wire logic sda_oe_m,
    input  wire logic sda_o_s,
    input  wire logic sda_oe_s,
    input  wire logic scl,
    input  wire logic sda
);
    logic       in_frame_ff;
    logic [3:0] cnt_ff;
    logic       scl_d_ff;
    logic       sda_d_ff;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // frame tracking
    // ----------------------------------------
    // cnt 1..9 is the clock of the byte; 1 also carries a repeated start or stop
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            in_frame_ff <= 1'b0;
            cnt_ff      <= 4'h0;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
            if (scl && scl_d_ff && !sda && sda_d_ff)
            begin
                in_frame_ff <= 1'b1;
                cnt_ff      <= 4'h0;
            end
            else if (scl && scl_d_ff && sda && !sda_d_ff)
                in_frame_ff <= 1'b0;
            else if (scl && !scl_d_ff && in_frame_ff)
                cnt_ff <= (cnt_ff == 4'h9) ? 4'h1 : cnt_ff + 4'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_slave_open_drain; sda_oe_s |-> !sda_o_s; endproperty
    a_slave_open_drain: assert property (p_slave_open_drain) else $error("slave drives sda high");
    property p_master_sda_od; sda_oe_m |-> !sda_o_m; endproperty
    a_master_sda_od: assert property (p_master_sda_od) else $error("master drives sda high");
    property p_master_scl_od; scl_oe_m |-> !scl_o_m; endproperty
    a_master_scl_od: assert property (p_master_scl_od) else $error("master drives scl high");
    property p_slave_in_frame; sda_oe_s |-> in_frame_ff; endproperty
    a_slave_in_frame: assert property (p_slave_in_frame) else $error("slave pulls sda outside a frame");
    property p_slave_moves_low; $changed(sda_oe_s) |-> !scl && !$past(scl); endproperty
    a_slave_moves_low: assert property (p_slave_moves_low) else $error("slave sda moved with scl high");
    property p_data_stable; scl && $past(scl) && in_frame_ff && cnt_ff >= 4'h2 |-> $stable(sda); endproperty
    a_data_stable: assert property (p_data_stable) else $error("sda moved in scl high of a bit");
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
    property p_ack_hold; $rose(scl) && cnt_ff == 4'h8 |-> ##1 $stable(sda) [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ninth bit not held");
endmodule : twb_bus_properties

// ### tb_serial_eeprom_two_wire_bus_port.sv
// self-checking bench joining master and slave ends over the bus carrier
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_serial_eeprom_two_wire_bus_port;
    import twb_pkg::*;
    localparam int unsigned WAIT_N = 50;
    localparam int unsigned POR_N  = 4;
    logic       core_clk_i, rstn_i, req, w_start, w_stop, rd, m_ack, tx_mode, ack_en, wr_busy;
    logic [7:0] wdata, tx_byte, rdata, rx_byte;
    logic       busy, done, acked, ready, active, start_p, stop_p, rx_v, tx_t, mst_ack;
    int         n_errors, check_count, n_start, n_stop, n_rx, n_tx, n;
    twb_if twb_if_i ();
    twb_master #(.WAIT_CYCLES(WAIT_N), .SCL_HALF(8)) twb_master_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .bus(twb_if_i.master), .req_i(req), .with_start_i(w_start), .with_stop_i(w_stop), .read_i(rd),
        .ack_i(m_ack), .wdata_i(wdata), .busy_o(busy), .done_o(done), .rdata_o(rdata), .acked_o(acked));
    twb_slave #(.POR_CYCLES(POR_N)) twb_slave_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(twb_if_i.slave),
        .tx_mode_i(tx_mode), .tx_byte_i(tx_byte), .ack_en_i(ack_en), .write_busy_i(wr_busy), .ready_o(ready),
        .active_o(active), .start_o(start_p), .stop_o(stop_p), .rx_valid_o(rx_v), .rx_byte_o(rx_byte),
        .tx_taken_o(tx_t), .master_ack_o(mst_ack));
    twb_bus_properties twb_bus_properties_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .scl_o_m(twb_if_i.scl_o_m), .scl_oe_m(twb_if_i.scl_oe_m), .sda_o_m(twb_if_i.sda_o_m),
        .sda_oe_m(twb_if_i.sda_oe_m), .sda_o_s(twb_if_i.sda_o_s), .sda_oe_s(twb_if_i.sda_oe_s),
        .scl(twb_if_i.scl), .sda(twb_if_i.sda));
    // ----------------------------------------
    // pulse counters
    // ----------------------------------------
    always @(posedge core_clk_i)
    begin
        n_start += (start_p === 1'b1);
        n_stop  += (stop_p === 1'b1);
        n_rx    += (rx_v === 1'b1);
        n_tx    += (tx_t === 1'b1);
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    // one byte through the master; waits for done, then idle, then lets the slave settle
    task xfer(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
        @(posedge core_clk_i);
        req     <= 1'b1;
        w_start <= s;
        w_stop  <= p;
        rd      <= r;
        m_ack   <= a;
        wdata   <= d;
        @(posedge core_clk_i);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (busy !== 1'b0 && n < 500)
        begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 400)
        begin
            n_errors++;
            close_out();
        end
        repeat (8) @(posedge core_clk_i);
    endtask : xfer
    task test_power;
        @(posedge core_clk_i);
        `CHK("ready_early", 1'b0, ready)
        repeat (POR_N + 3) @(posedge core_clk_i);
        `CHK("ready", 1'b1, ready)
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge core_clk_i);
            n++;
        end
        `CHK("cmd_wait", 1'b1, n >= WAIT_N - 12 && n < 200)
        `CHK("no_start", 0, n_start)
        `CHK("idle_lines", 1'b1, twb_if_i.scl & twb_if_i.sda)
        $display("test power done");
    endtask : test_power
    task test_write;
        ack_en <= 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA5);
        `CHK("start", 1, n_start)
        `CHK("rx_a5", 8'hA5, rx_byte)
        `CHK("acked", 1'b1, acked)
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h01);
        `CHK("rx_01", 8'h01, rx_byte)
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h80);
        `CHK("rx_80", 8'h80, rx_byte)
        `CHK("rx_count", 3, n_rx)
        `CHK("stop", 1, n_stop)
        `CHK("active", 1'b0, active)
        `CHK("idle_sda", 1'b1, twb_if_i.sda)
        ack_en <= 1'b0;
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h5A);
        `CHK("nacked", 1'b0, acked)
        `CHK("rx_5a", 8'h5A, rx_byte)
        $display("test write done");
    endtask : test_write
    task test_read;
        ack_en  <= 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
        tx_mode <= 1'b1;
        tx_byte <= 8'h3C;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA1);
        `CHK("restart", 4, n_start)
        tx_byte <= 8'hC3;
        xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        `CHK("rd_3c", 8'h3C, rdata)
        `CHK("mst_ack", 1'b1, mst_ack)
        `CHK("tx_taken", 1, n_tx)
        xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
        `CHK("rd_c3", 8'hC3, rdata)
        `CHK("mst_nack", 1'b0, mst_ack)
        `CHK("idle_rd", 1'b1, twb_if_i.sda)
        tx_mode <= 1'b0;
        $display("test read done");
    endtask : test_read
    task test_busy_stop;
        wr_busy <= 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h7E);
        `CHK("busy_stop", 4, n_stop)
        `CHK("busy_act", 1'b0, active)
        wr_busy <= 1'b0;
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h81);
        `CHK("rx_81", 8'h81, rx_byte)
        `CHK("acked_81", 1'b1, acked)
        $display("test busy stop done");
    endtask : test_busy_stop
    // ----------------------------------------
    // clock, reset and sequence
    // ----------------------------------------
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        {rstn_i, req, w_start, w_stop, rd, m_ack, tx_mode, ack_en, wr_busy} = '0;
        wdata   = 8'h00;
        tx_byte = 8'h00;
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        test_power();
        test_write();
        test_read();
        test_busy_stop();
        close_out();
    end
endmodule : tb_serial_eeprom_two_wire_bus_port
